// ===== design/flash_irq_clock_mux_pkg.sv
// Package for the flash, interrupt, clock divider and mux register bank.
// Assumes an 8-bit core with separate special-function and external
// data spaces, both run from sys_clk (the master clock).
package flash_irq_clock_mux_pkg;

	// ----------------------------------------------------------------
	// Special-function register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0]  SFR_CORE_PENDING   = 8'hC0;
	localparam logic [7:0]  SFR_IRQ_SRC_A      = 8'hE8;
	localparam logic [7:0]  SFR_IRQ_SRC_B      = 8'hF8;

	// ----------------------------------------------------------------
	// External data space addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] XD_SLOT_SELECT     = 16'h2104;
	localparam logic [15:0] XD_CPU_DIVIDER     = 16'h2200;
	localparam logic [15:0] XD_FLASH_CTRL      = 16'h2702;
	localparam logic [15:0] XD_RAW_IRQ         = 16'h2707;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          CORE_INT2_BIT      = 1;
	localparam int          CORE_INT6_BIT      = 5;
	localparam int          SLOT2_LSB          = 0;
	localparam int          SLOT3_LSB          = 4;
	localparam int          KEY_LSB            = 4;
	localparam int          READ_OK_BIT        = 2;
	localparam int          WRITE_OK_BIT       = 1;

	// Implemented source flag bits in each register
	localparam logic [7:0]  SRC_A_MASK         = 8'h7F;
	localparam logic [7:0]  SRC_B_MASK         = 8'h98;

	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [7:0]  FLAGS_RESET        = 8'h00;
	localparam logic [3:0]  SELECT_RESET       = 4'h0;
	localparam logic [2:0]  DIVIDER_RESET      = 3'h0;
	localparam logic [3:0]  KEY_RESET          = 4'h0;
	localparam logic [3:0]  KEY_UNLOCK_VALUE   = 4'h2;
	localparam logic [2:0]  DIVIDER_MAX        = 3'h4;
	localparam int          DIVIDER_BASE_EXP   = 2;
	localparam int          CPU_MIN_RATE_HZ    = 38400;

endpackage

// ===== design/irq_source_flags.sv
// Sticky interrupt source flags, cleared by writing zero.
// Assumes single-cycle write strobes and set pulses on sys_clk.
`timescale 1ns/1ps
module irq_source_flags
	import flash_irq_clock_mux_pkg::*;
#(
	parameter int         WIDTH = 8,
	parameter logic [7:0] MASK  = 8'hFF
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	// Hardware events
	input  wire logic [WIDTH-1:0] set_pulse,
	// Software write
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	// Flag state
	output logic      [WIDTH-1:0] flags_q
);

	logic [WIDTH-1:0] keep;
	logic [WIDTH-1:0] flags_d;

	// Zero clears, one keeps; a new event wins over a clear
	always_comb begin
		keep    = wr_en ? wr_data : {WIDTH{1'b1}}; // R12
		flags_d = ((flags_q & keep) | set_pulse) & MASK[WIDTH-1:0]; // R3
	end

	// Flag storage
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= FLAGS_RESET[WIDTH-1:0];
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule // irq_source_flags

// ===== design/cpu_clock_enable.sv
// Processor clock enable derived from the master clock by a power of two.
// Assumes sys_clk is the master clock; output is a one-cycle enable.
`timescale 1ns/1ps
module cpu_clock_enable
	import flash_irq_clock_mux_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// Divider setting
	input  wire logic [2:0] divider,
	// Processor clock enable
	output logic            cpu_clk_en
);

	logic [2:0] div_eff;
	logic [6:0] terminal;
	logic [6:0] count_q;

	// Clamp to the largest legal setting; period is 2^(2+div) cycles
	always_comb begin
		div_eff  = (divider > DIVIDER_MAX) ? DIVIDER_MAX : divider; // R9
		terminal = 7'((7'd1 << (DIVIDER_BASE_EXP + int'(div_eff))) - 7'd1); // R7
	end

	// Free-running counter, restarts at the period end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 7'h00;
		end else if (count_q >= terminal) begin
			count_q <= 7'h00;
		end else begin
			count_q <= count_q + 7'd1;
		end
	end

	assign cpu_clk_en = (count_q >= terminal); // R7

endmodule // cpu_clock_enable

// ===== design/flash_irq_clock_mux_regs.sv
// Register bank: flash key, interrupt source flags, raw interrupt view,
// processor clock divider and converter slot 2/3 input selects.
// Assumes the core drives one-cycle read and write strobes on sys_clk.
// Vector pulses come from the core as it enters the int2 or int6 handler.
`timescale 1ns/1ps

// How it works
// R1: Flash changes are enabled only while the four-bit key holds two.
// R2: A read-only bit tells whether the emulator or serial port may write flash.
// R3: Hardware sets the int2/5/6 source flags and they hold until software clears them.
// R4: The core-level int2 and int6 pending bits clear when the core vectors to them.
// R5: Software clears a core pending bit by writing zero there and ones elsewhere.
// R6: The live levels of interrupt inputs 0 to 6 read back with no latching.
// R7: The processor clock is the master clock divided by two to the (2 + divider).
// R8: Software keeps the divider at four or below.
// R9: The slowest processor clock comes from the largest divider setting.
// R10: Two four-bit selects, reset to zero, pick the inputs for slots 2 and 3.
// R11: Flash readability by the external ports is the inverse of code protection.
// R12: Writing zero clears a source flag and writing one leaves it alone.
module flash_irq_clock_mux_regs
	import flash_irq_clock_mux_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Special-function space
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// External data space
	input  wire logic [15:0] xd_addr,
	input  wire logic        xd_wr,
	input  wire logic        xd_rd,
	input  wire logic [7:0]  xd_wdata,
	output logic      [7:0]  xd_rdata,
	// Interrupt sources and core vectoring
	input  wire logic [7:0]  src_a_events,
	input  wire logic [7:0]  src_b_events,
	input  wire logic [6:0]  raw_irq_inputs,
	input  wire logic        vector_int2,
	input  wire logic        vector_int6,
	output logic             core_int2_pending,
	output logic             core_int6_pending,
	// Flash security
	input  wire logic        code_protection_on,
	output logic             flash_modify_en,
	output logic             flash_ext_write_ok,
	output logic             flash_ext_read_ok,
	// Clock and converter controls
	output logic             cpu_clk_en,
	output logic      [3:0]  slot2_input_select,
	output logic      [3:0]  slot3_input_select
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic       wr_src_a;
	logic       wr_src_b;
	logic       wr_pending;
	logic       wr_select;
	logic       wr_divider;
	logic       wr_flash;

	// Write strobes per register
	always_comb begin
		wr_src_a   = sfr_wr && (sfr_addr == SFR_IRQ_SRC_A);
		wr_src_b   = sfr_wr && (sfr_addr == SFR_IRQ_SRC_B);
		wr_pending = sfr_wr && (sfr_addr == SFR_CORE_PENDING);
		wr_select  = xd_wr && (xd_addr == XD_SLOT_SELECT);
		wr_divider = xd_wr && (xd_addr == XD_CPU_DIVIDER);
		wr_flash   = xd_wr && (xd_addr == XD_FLASH_CTRL);
	end

	// ----------------------------------------------------------------
	// Interrupt source flags
	// ----------------------------------------------------------------
	logic [7:0] src_a_flags;
	logic [7:0] src_b_flags;

	// Flags behind the first source register
	irq_source_flags #(
		.WIDTH (8),
		.MASK  (SRC_A_MASK)
	) u_src_a (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.set_pulse (src_a_events & SRC_A_MASK), // R3
		.wr_en     (wr_src_a),
		.wr_data   (sfr_wdata),
		.flags_q   (src_a_flags)
	);

	// Flags behind the second source register
	irq_source_flags #(
		.WIDTH (8),
		.MASK  (SRC_B_MASK)
	) u_src_b (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.set_pulse (src_b_events & SRC_B_MASK), // R3
		.wr_en     (wr_src_b),
		.wr_data   (sfr_wdata),
		.flags_q   (src_b_flags)
	);

	// ----------------------------------------------------------------
	// Core-level pending bits
	// ----------------------------------------------------------------
	logic       int2_set;
	logic       int6_set;
	logic       int2_q;
	logic       int6_q;
	logic       int2_zero_wr;
	logic       int6_zero_wr;

	// Group A events request int2, group B events request int6
	always_comb begin
		int2_set = |(src_a_events & SRC_A_MASK);
		int6_set = |(src_b_events & SRC_B_MASK);
	end

	// A zero in the pending byte clears that bit; ones leave it alone
	always_comb begin
		int2_zero_wr = wr_pending && !sfr_wdata[CORE_INT2_BIT]; // R5
		int6_zero_wr = wr_pending && !sfr_wdata[CORE_INT6_BIT]; // R5
	end

	// Vector or zero write clears; a new event wins
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			int2_q <= 1'b0;
		end else if (int2_set) begin
			int2_q <= 1'b1;
		end else if (vector_int2) begin
			int2_q <= 1'b0; // R4
		end else if (int2_zero_wr) begin
			int2_q <= 1'b0; // R5
		end
	end

	// Same precedence for int6
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			int6_q <= 1'b0;
		end else if (int6_set) begin
			int6_q <= 1'b1;
		end else if (vector_int6) begin
			int6_q <= 1'b0; // R4
		end else if (int6_zero_wr) begin
			int6_q <= 1'b0; // R5
		end
	end

	// Pending levels straight from their flops
	assign core_int2_pending = int2_q;
	assign core_int6_pending = int6_q;

	// ----------------------------------------------------------------
	// Converter slot selects
	// ----------------------------------------------------------------
	logic [3:0] slot2_q;
	logic [3:0] slot3_q;

	// Both selects share one byte
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			slot2_q <= SELECT_RESET; // R10
			slot3_q <= SELECT_RESET; // R10
		end else if (wr_select) begin
			slot2_q <= xd_wdata[SLOT2_LSB +: 4]; // R10
			slot3_q <= xd_wdata[SLOT3_LSB +: 4]; // R10
		end
	end

	// Selects go to the converter unchanged
	assign slot2_input_select = slot2_q;
	assign slot3_input_select = slot3_q;

	// ----------------------------------------------------------------
	// Processor clock divider
	// ----------------------------------------------------------------
	logic [2:0] divider_q;

	// Stored as written; out-of-range values are clamped downstream
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			divider_q <= DIVIDER_RESET;
		end else if (wr_divider) begin
			divider_q <= xd_wdata[2:0];
		end
	end

	// Enable pulse for the processor clock
	cpu_clock_enable u_cpu_clk (
		.sys_clk    (sys_clk),
		.rst_b      (rst_b),
		.divider    (divider_q),
		.cpu_clk_en (cpu_clk_en)
	);

	// ----------------------------------------------------------------
	// Flash key and status
	// ----------------------------------------------------------------
	logic [3:0] key_q;
	logic       unlocked;

	// Key register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			key_q <= KEY_RESET;
		end else if (wr_flash) begin
			key_q <= xd_wdata[KEY_LSB +: 4];
		end
	end

	// Status derived from key and protection
	always_comb begin
		unlocked           = (key_q == KEY_UNLOCK_VALUE); // R1
		flash_modify_en    = unlocked; // R1
		flash_ext_write_ok = unlocked && !code_protection_on; // R2
		flash_ext_read_ok  = !code_protection_on; // R11
	end

	// ----------------------------------------------------------------
	// Register images as a read sees them
	// ----------------------------------------------------------------
	logic [7:0] pending_img;
	logic [7:0] select_img;
	logic [7:0] divider_img;
	logic [7:0] flash_img;
	logic [7:0] raw_img;

	// Unused bit positions read as zero
	always_comb begin
		pending_img                = 8'h00;
		pending_img[CORE_INT2_BIT] = int2_q;
		pending_img[CORE_INT6_BIT] = int6_q;
		select_img                 = 8'h00;
		select_img[SLOT2_LSB +: 4] = slot2_q; // R10
		select_img[SLOT3_LSB +: 4] = slot3_q; // R10
		divider_img                = {5'h00, divider_q};
		flash_img                  = 8'h00;
		flash_img[KEY_LSB +: 4]    = key_q;
		flash_img[READ_OK_BIT]     = flash_ext_read_ok; // R11
		flash_img[WRITE_OK_BIT]    = flash_ext_write_ok; // R2
		raw_img                    = {1'b0, raw_irq_inputs}; // R6
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [7:0] sfr_mux;
	logic [7:0] xd_mux;
	logic [7:0] sfr_rdata_q;
	logic [7:0] xd_rdata_q;

	// Special-function read selection; unmapped reads give zero
	always_comb begin
		sfr_mux = 8'h00;
		case (sfr_addr)
			SFR_IRQ_SRC_A:    sfr_mux = src_a_flags;
			SFR_IRQ_SRC_B:    sfr_mux = src_b_flags;
			SFR_CORE_PENDING: sfr_mux = pending_img;
			default:          sfr_mux = 8'h00;
		endcase
	end

	// External data read selection; unmapped reads give zero
	always_comb begin
		xd_mux = 8'h00;
		case (xd_addr)
			XD_SLOT_SELECT: xd_mux = select_img;
			XD_CPU_DIVIDER: xd_mux = divider_img;
			XD_FLASH_CTRL:  xd_mux = flash_img;
			XD_RAW_IRQ:     xd_mux = raw_img;
			default:        xd_mux = 8'h00;
		endcase
	end

	// Read data registered on the strobe, held until the next read
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata_q <= sfr_mux;
		end
	end

	// External read data, same timing as the special-function side
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			xd_rdata_q <= 8'h00;
		end else if (xd_rd) begin
			xd_rdata_q <= xd_mux;
		end
	end

	// Read data leaves from flops
	assign sfr_rdata = sfr_rdata_q;
	assign xd_rdata  = xd_rdata_q;

endmodule // flash_irq_clock_mux_regs

// ===== tb/flash_irq_clock_mux_regs_checker.sv
// Assertions for the flash, interrupt, clock and mux register bank.
// Bound onto flash_irq_clock_mux_regs; sees only its ports.
`timescale 1ns/1ps
module flash_irq_clock_mux_regs_checker
	import flash_irq_clock_mux_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// Register buses
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [15:0] xd_addr,
	input wire logic        xd_wr,
	input wire logic [7:0]  xd_wdata,
	// Interrupts
	input wire logic [7:0]  src_a_events,
	input wire logic [7:0]  src_b_events,
	input wire logic        vector_int2,
	input wire logic        core_int2_pending,
	input wire logic        core_int6_pending,
	// Flash, clock, selects
	input wire logic        code_protection_on,
	input wire logic        flash_modify_en,
	input wire logic        flash_ext_write_ok,
	input wire logic        flash_ext_read_ok,
	input wire logic        cpu_clk_en,
	input wire logic [3:0]  slot2_input_select,
	input wire logic [3:0]  slot3_input_select
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence gap_s; !cpu_clk_en [*3]; endsequence
	sequence a_evt_s; |(src_a_events & SRC_A_MASK); endsequence

	property key_p;
		logic [3:0] k;
		(xd_wr && xd_addr == XD_FLASH_CTRL, k = xd_wdata[7:4])
		|=> flash_modify_en == (k == KEY_UNLOCK_VALUE);
	endproperty
	property slot_p;
		logic [7:0] v;
		(xd_wr && xd_addr == XD_SLOT_SELECT, v = xd_wdata)
		|=> {slot3_input_select, slot2_input_select} == v;
	endproperty

	key_gate_a: assert property (key_p)
		else $error("key gate wrong");
	write_ok_a: assert property (flash_ext_write_ok ==
		(flash_modify_en && !code_protection_on)) else $error("write ok");
	read_ok_a: assert property (flash_ext_read_ok ==
		!code_protection_on) else $error("read ok wrong");
	int2_set_a: assert property (a_evt_s |=> core_int2_pending)
		else $error("int2 not set");
	int6_set_a: assert property (|(src_b_events & SRC_B_MASK)
		|=> core_int6_pending) else $error("int6 not set");
	vec_clear_a: assert property (vector_int2 && !(|(src_a_events &
		SRC_A_MASK)) |=> !core_int2_pending) else $error("no clear");
	int2_hold_a: assert property (core_int2_pending && !vector_int2 &&
		!sfr_wr |=> core_int2_pending) else $error("int2 lost");
	clk_gap_a: assert property (cpu_clk_en |=> gap_s)
		else $error("clock enable too fast");
	slot_sel_a: assert property (slot_p)
		else $error("slot select wrong");
endmodule // flash_irq_clock_mux_regs_checker

bind flash_irq_clock_mux_regs flash_irq_clock_mux_regs_checker chk_u (
	.sys_clk, .rst_b, .sfr_addr, .sfr_wr, .xd_addr, .xd_wr, .xd_wdata,
	.src_a_events, .src_b_events, .vector_int2, .core_int2_pending,
	.core_int6_pending, .code_protection_on, .flash_modify_en,
	.flash_ext_write_ok, .flash_ext_read_ok, .cpu_clk_en,
	.slot2_input_select, .slot3_input_select);

// ===== tb/test_flash_irq_clock_mux_regs.sv
// Testbench for the flash, interrupt, clock and mux register bank.
// Assumes the package and checker are compiled first.
`timescale 1ns/1ps
module test_flash_irq_clock_mux_regs
	import flash_irq_clock_mux_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        sys_clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0;
	logic        xd_wr = 0, xd_rd = 0, vector_int2 = 0, vector_int6 = 0;
	logic        code_protection_on = 0, core_int2_pending;
	logic        core_int6_pending, flash_modify_en, flash_ext_write_ok;
	logic        flash_ext_read_ok, cpu_clk_en;
	logic [7:0]  sfr_addr = 0, sfr_wdata = 0, xd_wdata = 0;
	logic [7:0]  src_a_events = 0, src_b_events = 0, sfr_rdata, xd_rdata;
	logic [15:0] xd_addr = 0;
	logic [6:0]  raw_irq_inputs = 0;
	logic [3:0]  slot2_input_select, slot3_input_select;
	int          num_errors = 0, total_checks = 0;

	flash_irq_clock_mux_regs dut_u (.sys_clk, .rst_b, .sfr_addr, .sfr_wr,
		.sfr_rd, .sfr_wdata, .sfr_rdata, .xd_addr, .xd_wr, .xd_rd,
		.xd_wdata, .xd_rdata, .src_a_events, .src_b_events,
		.raw_irq_inputs, .vector_int2, .vector_int6, .core_int2_pending,
		.core_int6_pending, .code_protection_on, .flash_modify_en,
		.flash_ext_write_ok, .flash_ext_read_ok, .cpu_clk_en,
		.slot2_input_select, .slot3_input_select);

	// Clock
	always #2.5 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One bus access; strobe is high for a single edge
	task automatic acc(input bit sp, input bit w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk);
		{sfr_addr, xd_addr} <= {a[7:0], a};
		{sfr_wdata, xd_wdata} <= {d, d};
		{sfr_wr, sfr_rd, xd_wr, xd_rd} <= {sp & w, sp & !w, !sp & w, !sp & !w};
		@(posedge sys_clk);
		{sfr_wr, sfr_rd, xd_wr, xd_rd} <= 4'h0;
		#1 q = sp ? sfr_rdata : xd_rdata;
	endtask

	task automatic wr(input bit sp, input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(sp, 1, a, d, q);
	endtask

	task automatic rc(input bit sp, input logic [15:0] a, input logic [7:0] e);
		logic [7:0] q;
		acc(sp, 0, a, 8'h00, q);
		chk(q, e);
	endtask

	// Single-cycle event and vector pulses
	task automatic fire(input logic [7:0] a, b, input logic v2, v6);
		@(posedge sys_clk);
		{src_a_events, src_b_events, vector_int2, vector_int6} <= {a, b, v2, v6};
		@(posedge sys_clk);
		{src_a_events, src_b_events, vector_int2, vector_int6} <= 18'h0;
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rc(0, XD_SLOT_SELECT, 8'h00);
		rc(0, XD_CPU_DIVIDER, 8'h00);
		rc(0, XD_FLASH_CTRL, 8'h04);
		rc(1, SFR_IRQ_SRC_A, 8'h00);
		rc(1, SFR_IRQ_SRC_B, 8'h00);
		rc(0, 16'h1234, 8'h00);
	endtask

	task automatic t_slots;
		wr(0, XD_SLOT_SELECT, 8'h35);
		chk({slot3_input_select, slot2_input_select}, 8'h35);
		rc(0, XD_SLOT_SELECT, 8'h35);
	endtask

	// Every key value, protection off and on
	task automatic t_key;
		for (int k = 0; k < 16; k++) begin
			for (int p = 0; p < 2; p++) begin
				@(posedge sys_clk);
				code_protection_on <= p[0];
				wr(0, XD_FLASH_CTRL, {k[3:0], 4'hF});
				chk({5'h0, flash_ext_read_ok, flash_ext_write_ok,
					flash_modify_en}, {5'h0, !p[0], k == 2 && !p[0], k == 2});
				rc(0, XD_FLASH_CTRL, {k[3:0], 1'b0, !p[0],
					k == 2 && !p[0], 1'b0});
			end
		end
		@(posedge sys_clk);
		code_protection_on <= 1'b0;
	endtask

	task automatic t_flags;
		fire(8'h01, 8'h00, 0, 0);
		chk({6'h0, core_int6_pending, core_int2_pending}, 8'h01);
		wr(1, SFR_IRQ_SRC_A, 8'hFF);
		rc(1, SFR_IRQ_SRC_A, 8'h01);
		wr(1, SFR_IRQ_SRC_A, 8'hFE);
		rc(1, SFR_IRQ_SRC_A, 8'h00);
		fire(8'h00, 8'h00, 1, 0);
		chk({7'h0, core_int2_pending}, 8'h00);
		fire(8'h00, 8'hFF, 0, 0);
		rc(1, SFR_IRQ_SRC_B, 8'h98);
		fire(8'h00, 8'h00, 0, 1);
		chk({7'h0, core_int6_pending}, 8'h00);
		fire(8'h40, 8'h08, 0, 0);
		wr(1, SFR_CORE_PENDING, 8'hDF);
		chk({6'h0, core_int6_pending, core_int2_pending}, 8'h01);
		wr(1, SFR_CORE_PENDING, 8'hFD);
		chk({7'h0, core_int2_pending}, 8'h00);
		fork // Event against clear and vector in one cycle: the event wins
			fire(8'h01, 8'h00, 1, 0);
			wr(1, SFR_IRQ_SRC_A, 8'h00);
		join
		chk({7'h0, core_int2_pending}, 8'h01);
		rc(1, SFR_IRQ_SRC_A, 8'h01);
		wr(1, SFR_IRQ_SRC_B, 8'h00);
		rc(1, SFR_IRQ_SRC_B, 8'h00);
	endtask

	task automatic t_raw;
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			raw_irq_inputs <= i ? 7'h2A : 7'h55;
			rc(0, XD_RAW_IRQ, i ? 8'h2A : 8'h55);
		end
	endtask

	// Spacing of enable pulses for divider settings 0 to 5
	task automatic t_div;
		int n;
		for (int d = 0; d < 6; d++) begin
			wr(0, XD_CPU_DIVIDER, 8'(d));
			n = 0;
			do begin @(negedge sys_clk); n++; end while (!cpu_clk_en && n < 200);
			n = 0;
			do begin @(negedge sys_clk); n++; end while (!cpu_clk_en && n < 200);
			chk(8'(n), 8'(4 << (d > 4 ? 4 : d)));
		end
		rc(0, XD_CPU_DIVIDER, 8'h05);
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic give_verdict;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence after a 12-cycle reset
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset;
		t_slots;
		t_key;
		t_flags;
		t_raw;
		t_div;
		give_verdict;
	end

	// Watchdog
	initial begin
		#100_000;
		num_errors++;
		give_verdict;
	end
endmodule // test_flash_irq_clock_mux_regs
